// file: verilog/eelc_pkg.sv
package eelc_pkg;

    // line counts
    localparam int LINES = 32;
    localparam int EXT_LINES = 16;
    localparam int GPIO_SRCS = 88;
    localparam int INT_LINES = 15;
    localparam int SUPPLY_LINE = 31;
    localparam int SEL_W = 8;

    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_INT_MASK = 8'h00;
    localparam logic [7:0] OFS_EVT_MASK = 8'h04;
    localparam logic [7:0] OFS_RISE_SEL = 8'h08;
    localparam logic [7:0] OFS_FALL_SEL = 8'h0C;
    localparam logic [7:0] OFS_SOFT_TRIG = 8'h10;
    localparam logic [7:0] OFS_PENDING = 8'h14;
    localparam logic [7:0] OFS_SRC_SEL0 = 8'h18;
    localparam logic [7:0] OFS_SRC_SEL3 = 8'h24;

    // reset values
    localparam logic [31:0] RST_INT_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_EVT_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_RISE_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_FALL_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_SRC_SEL = 32'h0000_0000;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: verilog/eelc_edge_capture.sv
`timescale 1ns/1ps
module eelc_edge_capture (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic src,
    input wire logic rise_en,
    input wire logic fall_en,
    output logic hit
);

    logic rise_tog;
    logic fall_tog;
    logic [2:0] rise_sync;
    logic [2:0] fall_sync;

    // the line itself clocks these toggles, so a pulse shorter than one
    // clock period still flips them; nothing here depends on sampling
    always_ff @(posedge src or negedge rst_b) begin
        if (!rst_b) begin
            rise_tog <= 1'b0;
        end else begin
            rise_tog <= ~rise_tog;
        end
    end

    always_ff @(negedge src or negedge rst_b) begin
        if (!rst_b) begin
            fall_tog <= 1'b0;
        end else begin
            fall_tog <= ~fall_tog;
        end
    end

    // two-stage synchronisers, third stage only for change detection
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rise_sync <= 3'h0;
            fall_sync <= 3'h0;
        end else if (clk_en) begin
            rise_sync <= {rise_sync[1:0], rise_tog};
            fall_sync <= {fall_sync[1:0], fall_tog};
        end
    end

    // edge selection per line: rising, falling or both
    always_comb begin
        hit = ((rise_sync[2] ^ rise_sync[1]) & rise_en)
            | ((fall_sync[2] ^ fall_sync[1]) & fall_en);
    end

endmodule

// file: verilog/eelc_controller.sv
`timescale 1ns/1ps
// Notes on behaviour
// - thirty-two edge lines, each raising interrupt, event and wake-up requests
// - each line separately selects rising, falling or both edges as trigger
// - each line has its own mask; masking one leaves others untouched
// - a pending bit per line records a trigger and software reads it
// - edges are caught asynchronously, so pulses shorter than a clock count
// - lines 0 to 15 each pick their source from 88 general-purpose pins
// - line 31 follows the secondary supply monitor comparator output
module eelc_controller (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // line sources
    input wire logic [87:0] gpio_in,
    input wire logic [14:0] internal_line,
    input wire logic secondary_io_supply_low,
    // requests
    output logic irq,
    output logic [31:0] event_req,
    output logic wakeup,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // software visible state
    logic [31:0] int_mask;
    logic [31:0] evt_mask;
    logic [31:0] rise_sel;
    logic [31:0] fall_sel;
    logic [31:0] soft_trig;
    logic [31:0] pending;
    logic [31:0] src_sel [0:3];

    // write channel holding state
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // internal wires
    logic [31:0] line_src;
    logic [31:0] hit;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr_fire;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_val;
    logic [31:0] soft_set;
    logic [31:0] pend_clr;
    logic [31:0] trig;

    // byte strobes widen to a bit mask
    always_comb begin
        wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
        wval = w_data_q & wmask;
    end

    // a write goes ahead once address and data are both held
    always_comb begin
        wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    end

    // decode of mapped offsets; anything else answers with an error
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a[1:0] == 2'h0) && (a <= eelc_pkg::OFS_SRC_SEL3);
    endfunction

    always_comb begin
        wr_ok = addr_mapped(aw_addr_q);
        rd_ok = addr_mapped(s_axi_araddr);
    end

    // source selection for the external lines; an index past the last pin
    // gives a quiet low input rather than an unknown one
    // note: retargeting a line can itself look like an edge, so software
    // should mask the line while changing its source
    always_comb begin
        line_src = 32'h0000_0000;
        for (int i = 0; i < eelc_pkg::EXT_LINES; i++) begin
            logic [7:0] s;
            s = src_sel[i / 4][(i % 4) * eelc_pkg::SEL_W +: eelc_pkg::SEL_W];
            if (s < 8'(eelc_pkg::GPIO_SRCS)) begin
                line_src[i] = gpio_in[s[6:0]];
            end
        end
        line_src[30:16] = internal_line;
        line_src[eelc_pkg::SUPPLY_LINE] = secondary_io_supply_low;
    end

    // one asynchronous edge catcher per line
    genvar g;
    generate
        for (g = 0; g < eelc_pkg::LINES; g++) begin : gen_line
            eelc_edge_capture u_cap (
                .clock(clock),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .src(line_src[g]),
                .rise_en(rise_sel[g]),
                .fall_en(fall_sel[g]),
                .hit(hit[g])
            );
        end
    endgenerate

    // software trigger and pending-clear masks from the current write
    always_comb begin
        soft_set = 32'h0000_0000;
        pend_clr = 32'h0000_0000;
        if (wr_fire && wr_ok && aw_addr_q == eelc_pkg::OFS_SOFT_TRIG) begin
            soft_set = wval;
        end
        if (wr_fire && wr_ok && aw_addr_q == eelc_pkg::OFS_PENDING) begin
            pend_clr = wval;
        end
        trig = hit | soft_set;
    end

    // configuration registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_mask <= eelc_pkg::RST_INT_MASK;
            evt_mask <= eelc_pkg::RST_EVT_MASK;
            rise_sel <= eelc_pkg::RST_RISE_SEL;
            fall_sel <= eelc_pkg::RST_FALL_SEL;
            for (int k = 0; k < 4; k++) begin
                src_sel[k] <= eelc_pkg::RST_SRC_SEL;
            end
        end else if (clk_en && wr_fire && wr_ok) begin
            case (aw_addr_q)
                eelc_pkg::OFS_INT_MASK: begin
                    int_mask <= (int_mask & ~wmask) | wval;
                end
                eelc_pkg::OFS_EVT_MASK: begin
                    evt_mask <= (evt_mask & ~wmask) | wval;
                end
                eelc_pkg::OFS_RISE_SEL: begin
                    rise_sel <= (rise_sel & ~wmask) | wval;
                end
                eelc_pkg::OFS_FALL_SEL: begin
                    fall_sel <= (fall_sel & ~wmask) | wval;
                end
                default: begin
                    if (aw_addr_q >= eelc_pkg::OFS_SRC_SEL0) begin
                        src_sel[aw_addr_q[3:2] - 2'h2] <=
                            (src_sel[aw_addr_q[3:2] - 2'h2] & ~wmask) | wval;
                    end
                end
            endcase
        end
    end

    // pending bits: a new trigger wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pending <= 32'h0000_0000;
        end else if (clk_en) begin
            pending <= (pending & ~pend_clr) | trig;
        end
    end

    // software trigger bits read back until their pending bit is cleared
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            soft_trig <= 32'h0000_0000;
        end else if (clk_en) begin
            soft_trig <= (soft_trig & ~pend_clr) | soft_set;
        end
    end

    // request outputs, all registered
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
            event_req <= 32'h0000_0000;
            wakeup <= 1'b0;
        end else if (clk_en) begin
            irq <= |(pending & int_mask);
            event_req <= trig & evt_mask;
            wakeup <= (|(pending & int_mask)) | (|(trig & evt_mask));
        end
    end

    // write address channel
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aw_hold <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_hold <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            w_hold <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_hold <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response; ready flags reopen only after it is taken, which
    // keeps one write in flight at the cost of a little throughput
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= eelc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? eelc_pkg::RESP_OKAY : eelc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            eelc_pkg::OFS_INT_MASK: rd_val = int_mask;
            eelc_pkg::OFS_EVT_MASK: rd_val = evt_mask;
            eelc_pkg::OFS_RISE_SEL: rd_val = rise_sel;
            eelc_pkg::OFS_FALL_SEL: rd_val = fall_sel;
            eelc_pkg::OFS_SOFT_TRIG: rd_val = soft_trig;
            eelc_pkg::OFS_PENDING: rd_val = pending;
            default: begin
                if (rd_ok && s_axi_araddr >= eelc_pkg::OFS_SRC_SEL0) begin
                    rd_val = src_sel[s_axi_araddr[3:2] - 2'h2];
                end
            end
        endcase
    end

    // read channel: data is captured at the address handshake
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= eelc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? eelc_pkg::RESP_OKAY : eelc_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// file: sim/eelc_line_model.sv
`timescale 1ns/1ps
// pin, internal and supply monitor sources; every line idles low
module eelc_line_model (
    output logic [87:0] gpio_in,
    output logic [14:0] internal_line,
    output logic secondary_io_supply_low
);
    initial begin
        gpio_in = '0;
        internal_line = '0;
        secondary_io_supply_low = 1'b0;
    end
    // index 88..102 reaches the internal lines, 103 the supply monitor
    task automatic drive(input int idx, input logic v);
        if (idx < 88) gpio_in[idx] = v;
        else if (idx < 103) internal_line[idx-88] = v;
        else secondary_io_supply_low = v;
    endtask
    // one ns wide, so only an asynchronous catch can see it
    task automatic glitch(input int idx);
        #1 drive(idx, 1'b1);
        #1 drive(idx, 1'b0);
    endtask
endmodule

// file: sim/eelc_controller_checker.sv
`timescale 1ns/1ps
module eelc_controller_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic irq,
    input wire logic [31:0] event_req,
    input wire logic wakeup,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // bus answers come within the slave's fixed latency and stand until taken
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
    // places past the last register or off a word boundary are refused
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready
        && (s_axi_araddr > 8'h24 || s_axi_araddr[1:0] != 2'h0) |=>
        s_axi_rresp == eelc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("bad read not refused");
    a_good_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr <= 8'h24 && s_axi_araddr[1:0] == 2'h0 |=>
        s_axi_rresp == eelc_pkg::RESP_OKAY) else $error("good read refused");
    a_wake_follows: assert property (irq || (|event_req) |-> ##[0:1] wakeup)
        else $error("request without wakeup");
    a_release_quiet: assert property ($rose(rst_b) |-> !irq && !s_axi_bvalid
        && !s_axi_rvalid && event_req == 32'h0000_0000) else $error("busy after reset");
endmodule
bind eelc_controller eelc_controller_checker chk_i (
    .clock(clock),
    .rst_b(rst_b),
    .irq(irq),
    .event_req(event_req),
    .wakeup(wakeup),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0, rst_b, clk_en = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, event_req, seen;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic irq, wakeup, secondary_io_supply_low;
    logic [87:0] gpio_in;
    logic [14:0] internal_line;
    logic [31:0] evt_seen = 32'h0000_0000;
    int err_count = 0, num_checks = 0;
    always #2.5 clock = ~clock;
    eelc_line_model pins (
        .gpio_in(gpio_in),
        .internal_line(internal_line),
        .secondary_io_supply_low(secondary_io_supply_low)
    );
    eelc_controller uut (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .gpio_in(gpio_in),
        .internal_line(internal_line),
        .secondary_io_supply_low(secondary_io_supply_low),
        .irq(irq),
        .event_req(event_req),
        .wakeup(wakeup),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    // event pulses last one cycle, so keep a sticky copy to look at later
    always @(posedge clock) if (rst_b) evt_seen <= evt_seen | event_req;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic stall();
        chk(32'h1, 32'h0);
        results();
    endtask
    // each channel is dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hF);
        int n;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
        if (n == 50) stall();
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        seen = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) stall();
    endtask
    // sync plus pending plus irq stages all fit in eight cycles
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask
    initial begin
        // reset must fall, not start low: the edge toggles are clocked only
        // by their line or by a falling reset, so they would stay unknown
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a <= 36; a += 4) begin
            rd(a[7:0]);
            chk(seen, 32'h0000_0000);
            chk(32'(resp), 32'(eelc_pkg::RESP_OKAY));
        end
        rd(8'h28);
        chk(32'(resp), 32'(eelc_pkg::RESP_SLVERR));
        wr(eelc_pkg::OFS_INT_MASK, 32'hFFFF_FFFF);
        chk(32'(resp), 32'(eelc_pkg::RESP_OKAY));
        wr(eelc_pkg::OFS_INT_MASK, 32'h0000_0000, 4'h1);
        rd(eelc_pkg::OFS_INT_MASK);
        chk(seen, 32'hFFFF_FF00);
        // an unaligned write is refused and leaves the mask alone
        wr(8'h01, 32'h0000_0000);
        chk(32'(resp), 32'(eelc_pkg::RESP_SLVERR));
        rd(eelc_pkg::OFS_INT_MASK);
        chk(seen, 32'hFFFF_FF00);
        // line 0 from pin 5; lines 1..3 from pin 87 as rise, fall and both
        wr(eelc_pkg::OFS_SRC_SEL0, 32'h5757_5705);
        wr(eelc_pkg::OFS_RISE_SEL, 32'h8001_000B);
        wr(eelc_pkg::OFS_FALL_SEL, 32'h0000_000C);
        wr(eelc_pkg::OFS_INT_MASK, 32'h0000_0001);
        settle();
        // a select change may fake one trigger, so clear before arming events
        wr(eelc_pkg::OFS_PENDING, 32'hFFFF_FFFF);
        wr(eelc_pkg::OFS_EVT_MASK, 32'h0001_0000);
        pins.glitch(5);
        settle();
        rd(eelc_pkg::OFS_PENDING);
        chk(seen, 32'h0000_0001);
        chk(32'(irq), 32'h1);
        wr(eelc_pkg::OFS_PENDING, 32'h0000_0001);
        settle();
        chk(32'(irq), 32'h0);
        pins.drive(87, 1'b1);
        settle();
        rd(eelc_pkg::OFS_PENDING);
        chk(seen, 32'h0000_000A);
        wr(eelc_pkg::OFS_PENDING, 32'h0000_000A);
        pins.drive(87, 1'b0);
        settle();
        rd(eelc_pkg::OFS_PENDING);
        chk(seen, 32'h0000_000C);
        pins.drive(88, 1'b1);
        settle();
        chk(evt_seen, 32'h0001_0000);
        wr(eelc_pkg::OFS_PENDING, 32'hFFFF_FFFF);
        pins.drive(103, 1'b1);
        settle();
        rd(eelc_pkg::OFS_PENDING);
        chk(seen, 32'h8000_0000);
        chk(32'(irq), 32'h0);
        wr(eelc_pkg::OFS_INT_MASK, 32'h8000_0000);
        settle();
        chk(32'(irq), 32'h1);
        chk(32'(wakeup), 32'h1);
        // clock enable low: the toggle still flips, nothing moves until it returns
        wr(eelc_pkg::OFS_PENDING, 32'hFFFF_FFFF);
        wr(eelc_pkg::OFS_INT_MASK, 32'h0000_0001);
        settle();
        chk(32'(irq), 32'h0);
        clk_en <= 1'b0;
        pins.glitch(5);
        settle();
        chk(32'(irq), 32'h0);
        clk_en <= 1'b1;
        settle();
        chk(32'(irq), 32'h1);
        // software trigger sets pending and reads back until its bit is cleared
        wr(eelc_pkg::OFS_SOFT_TRIG, 32'h0000_0100);
        rd(eelc_pkg::OFS_SOFT_TRIG);
        chk(seen, 32'h0000_0100);
        rd(eelc_pkg::OFS_PENDING);
        chk(seen, 32'h0000_0101);
        wr(eelc_pkg::OFS_PENDING, 32'h0000_0100);
        rd(eelc_pkg::OFS_SOFT_TRIG);
        chk(seen, 32'h0000_0000);
        results();
    end
endmodule
